// ### design/gdp_fault_protect.sv
// Category A fault protection: Vce saturation, overcurrent, external enable, stage monitor.
// Assumes analog comparators and drive-line sensors on pins, and an operating-mode
// state machine on clk that supplies PWM command and sequence pulses.
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module gdp_fault_protect #(
  parameter int OSM_CYC = gdp_pkg::OSM_INHIBIT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog comparators and pins (asynchronous)
  input wire logic [gdp_pkg::NUM_VCE_THR-1:0] vceCmpIn,
  input wire logic ocCmpLowIn,
  input wire logic ocCmpHighIn,
  input wire logic extEnableValidIn,
  input wire logic boosterOnDriveIn,
  input wire logic boosterOffDriveIn,
  input wire logic outputDisableIn,
  // Operating-mode state machine (same clock)
  input wire logic pwmOn,
  input wire logic turnOnStart,
  input wire logic plateauActive,
  input wire logic hardOffStart,
  input wire logic [2:0] opMode,
  // Actions
  output logic vcePullDown,
  output logic vceClampOut,
  output logic outputTristate,
  output logic emergencyOffReq,
  output logic emergencySafe,
  output logic faultNotifyAN
);
  import gdp_pkg::*;

  // ----------------------------------------------------------------
  // Reset and input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rstSync_q;
  logic rstSyncN;
  localparam int NSYNC = NUM_VCE_THR + 6;
  logic [NSYNC-1:0] pinRaw;
  logic [NSYNC-1:0] pinMeta_q;
  logic [NSYNC-1:0] pinSync_q;

  // Reset release through two stages so every flop leaves reset on the same edge
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rstSync_q <= 2'b00;
    else
      rstSync_q <= {rstSync_q[0], 1'b1};
  end
  assign rstSyncN = rstSync_q[1];

  assign pinRaw = {outputDisableIn, boosterOffDriveIn, boosterOnDriveIn, extEnableValidIn,
                   ocCmpHighIn, ocCmpLowIn, vceCmpIn};

  // Only the second stage is read by logic
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
    end
    else
    begin
      pinMeta_q <= pinRaw;
      pinSync_q <= pinMeta_q;
    end
  end

  logic [NUM_VCE_THR-1:0] vceCmp;
  logic ocLow, ocHigh, enValid, onDrive, offDrive, osdLevel;
  assign vceCmp = pinSync_q[NUM_VCE_THR-1:0];
  assign ocLow = pinSync_q[NUM_VCE_THR];
  assign ocHigh = pinSync_q[NUM_VCE_THR+1];
  assign enValid = pinSync_q[NUM_VCE_THR+2];
  assign onDrive = pinSync_q[NUM_VCE_THR+3];
  assign offDrive = pinSync_q[NUM_VCE_THR+4];
  assign osdLevel = pinSync_q[NUM_VCE_THR+5];

  // ----------------------------------------------------------------
  // Registers and APB decode
  // ----------------------------------------------------------------
  logic [3:0] cfg_q, err_q, err_d, errW1c;
  logic [BLANK_W-1:0] vceBlank_q, ocBlank_q;
  logic [31:0] rdData;
  logic [1:0] thrSel;
  logic ocSticky_q, hz_q, trip_q, wrStb, mapped, clrSticky, hzClear, clampEn, osmDisable;
  logic selCfg, selCmd, selBlank, selErr, selStat;

  assign selCfg = (paddr == ADDR_CFG);
  assign selCmd = (paddr == ADDR_CMD);
  assign selBlank = (paddr == ADDR_BLANK);
  assign selErr = (paddr == ADDR_ERR);
  assign selStat = (paddr == ADDR_STAT);
  assign mapped = selCfg | selCmd | selBlank | selErr | selStat;
  assign wrStb = psel & penable & pwrite & mapped;
  // Zero wait states; unmapped addresses answer with an error and no effect
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign clrSticky = wrStb & selCmd & pwdata[CMD_CLRS_BIT];
  assign hzClear = wrStb & selCmd & pwdata[CMD_HZCLR_BIT];
  assign errW1c = (wrStb & selErr) ? pwdata[3:0] : 4'h0;
  assign thrSel = cfg_q[CFG_THR_LSB+1:CFG_THR_LSB];
  assign clampEn = cfg_q[CFG_CLAMP_BIT];
  assign osmDisable = cfg_q[CFG_OSMD_BIT];

  // Configuration writes
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      cfg_q <= CFG_RST;
      vceBlank_q <= VCE_BLANK_RST;
      ocBlank_q <= OC_BLANK_RST;
    end
    else if (wrStb)
    begin
      if (selCfg)
        cfg_q <= pwdata[3:0];
      if (selBlank)
      begin
        vceBlank_q <= pwdata[BLANK_VCE_LSB+BLANK_W-1:BLANK_VCE_LSB];
        ocBlank_q <= pwdata[BLANK_OC_LSB+BLANK_W-1:BLANK_OC_LSB];
      end
    end
  end

  // ----------------------------------------------------------------
  // Vce saturation supervision
  // ----------------------------------------------------------------
  logic [BLANK_W-1:0] vceCnt_q;
  logic vceHit;
  logic vceHitPrev_q;
  logic vceEvt;

  // Reloaded at turn-on and at the hard switching after the plateau
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      vceCnt_q <= '0;
    else if (turnOnStart | hardOffStart)
      vceCnt_q <= vceBlank_q;
    else if (vceCnt_q != '0)
      vceCnt_q <= vceCnt_q - 1'b1;
  end

  assign vcePullDown = (vceCnt_q != '0) | plateauActive | vceClampOut;
  assign vceClampOut = clampEn & ~pwmOn;
  // An open pin floats high, so the first compare after blanking trips
  assign vceHit = pwmOn & (vceCnt_q == '0) & ~turnOnStart & vceCmp[thrSel];
  assign vceEvt = vceHit & ~vceHitPrev_q;

  // ----------------------------------------------------------------
  // Overcurrent supervision
  // ----------------------------------------------------------------
  logic [BLANK_W-1:0] ocCnt_q;
  logic ocArmed;
  logic ocLowEval;
  logic ocHighEval;
  logic ocHitPrev_q;
  logic ocEvt;

  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      ocCnt_q <= '0;
    else if (turnOnStart)
      ocCnt_q <= ocBlank_q;
    else if (ocCnt_q != '0)
      ocCnt_q <= ocCnt_q - 1'b1;
  end

  // Status bits and fault share the blanked, PWM-gated view of the comparators
  assign ocArmed = pwmOn & (ocCnt_q == '0) & ~turnOnStart;
  assign ocLowEval = ocArmed & ocLow;
  assign ocHighEval = ocArmed & ocHigh;
  assign ocEvt = ocLowEval & ~ocHitPrev_q;

  // ----------------------------------------------------------------
  // External enable
  // ----------------------------------------------------------------
  logic enPrev_q;
  logic enEvt;
  assign enEvt = enPrev_q & ~enValid;

  // ----------------------------------------------------------------
  // Output stage monitoring
  // ----------------------------------------------------------------
  localparam int OSM_W = $clog2(OSM_CYC + 1);
  logic [OSM_W-1:0] osmCnt_q;
  logic osdPrev_q, osdFall, tristateNow, osmActive, onCheck;
  logic mismatch, hzSet, hzRise, hzRelease;

  assign tristateNow = hz_q | osdLevel;
  assign osmActive = ~osmDisable & ~tristateNow & (osmCnt_q == '0);
  assign onCheck = (opMode != OPM_FIVE) & (opMode != OPM_SIX);
  // Expected: on-drive follows the command, off-drive is its complement
  assign mismatch = (onCheck & (onDrive != pwmOn)) | (offDrive == pwmOn);
  assign hzSet = osmActive & mismatch & ~turnOnStart & ~hardOffStart;
  assign hzRise = hzSet & ~hz_q;
  assign hzRelease = hzClear & hz_q & ~hzSet;
  assign osdFall = osdPrev_q & ~osdLevel;
  assign outputTristate = tristateNow;

  // Inhibit counted from reset, each commutation and each tristate clear command that releases a set tristate; the synchronisers
  // come out of reset low, which would otherwise look like an off-drive mismatch
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      osmCnt_q <= OSM_W'(OSM_CYC);
    else if (turnOnStart | hardOffStart | hzRelease)
      osmCnt_q <= OSM_W'(OSM_CYC);
    else if (osmCnt_q != '0)
      osmCnt_q <= osmCnt_q - 1'b1;
  end

  // ----------------------------------------------------------------
  // Flags, sticky bits and edge history
  // ----------------------------------------------------------------
  // Set wins over a software clear landing in the same cycle
  assign err_d = (err_q & ~errW1c) |
                 {hzRise, enEvt, ocEvt, vceEvt};

  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      err_q <= 4'h0;
      ocSticky_q <= 1'b0;
      hz_q <= 1'b0;
      trip_q <= 1'b0;
      vceHitPrev_q <= 1'b0;
      ocHitPrev_q <= 1'b0;
      enPrev_q <= 1'b0;
      osdPrev_q <= 1'b0;
    end
    else
    begin
      err_q <= err_d;
      ocSticky_q <= ocHighEval | (ocSticky_q & ~clrSticky);
      hz_q <= hzSet | (hz_q & ~hzClear);
      trip_q <= hzRise | (trip_q & ~(clrSticky | osdFall));
      vceHitPrev_q <= vceHit;
      ocHitPrev_q <= ocLowEval;
      enPrev_q <= enValid;
      osdPrev_q <= osdLevel;
    end
  end

  // One request per fault onset; the tag marks the safe sequence
  assign emergencyOffReq = vceEvt | ocEvt | enEvt | hzRise;
  assign emergencySafe = vceEvt | ocEvt;
  // Notification stays low until every error flag has been cleared
  assign faultNotifyAN = ~(|err_q);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  assign rdData = selCfg ? {28'h0, cfg_q} :
                  selBlank ? {6'h0, ocBlank_q, 6'h0, vceBlank_q} :
                  selErr ? {28'h0, err_q} :
                  selStat ? {26'h0, trip_q, hz_q, enValid, ocSticky_q, ocHighEval, ocLowEval} :
                  32'h0;

  // Captured in the setup cycle so data is stable through the access phase
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      prdata <= 32'h0;
    else if (psel & ~penable & ~pwrite)
      prdata <= rdData;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_safe_req;
    emergencyOffReq && emergencySafe;
  endsequence

  sequence s_flag_notify(flag);
    flag && !faultNotifyAN;
  endsequence

  property p_vce_trip;
    @(posedge clk) disable iff (!rstSyncN)
      vceEvt |-> s_safe_req ##1 s_flag_notify(err_q[ERR_VCE_BIT]);
  endproperty
  a_vce_trip: assert property (p_vce_trip) else $error("vce fault did not trip");

  property p_vce_pwm_off;
    @(posedge clk) disable iff (!rstSyncN)
      !pwmOn |-> !vceEvt && !ocEvt;
  endproperty
  a_vce_pwm_off: assert property (p_vce_pwm_off) else $error("fault raised while pwm off");

  property p_vce_blank;
    @(posedge clk) disable iff (!rstSyncN)
      (turnOnStart && vceBlank_q >= 10'h003) |=> (vcePullDown && !vceEvt) [*3];
  endproperty
  a_vce_blank: assert property (p_vce_blank) else $error("vce not held low in blanking");

  property p_plateau;
    @(posedge clk) disable iff (!rstSyncN)
      plateauActive |-> vcePullDown;
  endproperty
  a_plateau: assert property (p_plateau) else $error("vce released in plateau");

  property p_clamp;
    @(posedge clk) disable iff (!rstSyncN)
      $fell(pwmOn) && clampEn |-> vceClampOut && vcePullDown;
  endproperty
  a_clamp: assert property (p_clamp) else $error("vce clamp missing");

  property p_oc_blank;
    @(posedge clk) disable iff (!rstSyncN)
      (ocCnt_q != '0) |-> !ocLowEval && !ocHighEval && !ocEvt;
  endproperty
  a_oc_blank: assert property (p_oc_blank) else $error("overcurrent seen in blanking");

  property p_oc_sticky;
    @(posedge clk) disable iff (!rstSyncN)
      ocHighEval |=> ocSticky_q;
  endproperty
  a_oc_sticky: assert property (p_oc_sticky) else $error("level two sticky not set");

  property p_en_trip;
    @(posedge clk) disable iff (!rstSyncN)
      $fell(enValid) |-> emergencyOffReq && !emergencySafe ##1 s_flag_notify(err_q[ERR_EN_BIT]);
  endproperty
  a_en_trip: assert property (p_en_trip) else $error("enable loss not handled");

  property p_stage_event;
    @(posedge clk) disable iff (!rstSyncN)
      hzSet && !hz_q |=> hz_q && trip_q && err_q[ERR_STAGE_BIT] && outputTristate;
  endproperty
  a_stage_event: assert property (p_stage_event) else $error("stage event incomplete");

  property p_osm_quiet;
    @(posedge clk) disable iff (!rstSyncN)
      (osmDisable || osmCnt_q != '0 || outputTristate) |-> !hzSet;
  endproperty
  a_osm_quiet: assert property (p_osm_quiet) else $error("stage monitor not inhibited");

  property p_trip_clear;
    @(posedge clk) disable iff (!rstSyncN)
      (clrSticky || osdFall) && !hzRise |=> !trip_q;
  endproperty
  a_trip_clear: assert property (p_trip_clear) else $error("stage trip not cleared");
endmodule
`default_nettype wire

// ### design/gdp_pkg.sv
// Constants, register map and field layout of the gate driver fault protection block.
// Assumes a 200 MHz system clock and an APB master with 32-bit data.
// How it works
// - Vce over threshold after blanking trips safely
// - No Vce supervision while PWM is off
// - Vce threshold chosen by select field
// - Vce pulled down through plateau plus blanking
// - Open Vce input faults at next turn-on
// - Clamp Vce input whenever PWM off, if enabled
// - Overcurrent ignored during its blanking time
// - Overcurrent level one trips safely, flags, notifies
// - Overcurrent level two sets a sticky bit
// - Overcurrent comparator status blanked while blanking
// - No overcurrent supervision while PWM is off
// - Open overcurrent input produces a fault event
// - Enable going invalid trips regularly, flags, notifies
// - Enable validity readable as status
// - Drive line mismatch tristates output, sets status
// - Drive line mismatch tristate rising sets trip, error, notification
// - Stage monitor inhibited after each commutation
// - Trip cleared by command or disable falling
// - Modes five and six skip on-drive check
// - No stage monitoring while already tristated
// - Tristate clear releases output, re-blanks monitor
// - Vce forced low for blanking at turn-on
package gdp_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int OSM_INHIBIT_NS = 1000;
  localparam int OSM_INHIBIT_CYC = (OSM_INHIBIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_W = 10;
  localparam int NUM_VCE_THR = 4;
  // Register byte offsets
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_BLANK = 8'h08;
  localparam logic [7:0] ADDR_ERR = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  // Field positions
  localparam int CFG_THR_LSB = 0;
  localparam int CFG_CLAMP_BIT = 2;
  localparam int CFG_OSMD_BIT = 3;
  localparam int CMD_CLRS_BIT = 0;
  localparam int CMD_HZCLR_BIT = 1;
  localparam int BLANK_VCE_LSB = 0;
  localparam int BLANK_OC_LSB = 16;
  localparam int ERR_VCE_BIT = 0;
  localparam int ERR_OC_BIT = 1;
  localparam int ERR_EN_BIT = 2;
  localparam int ERR_STAGE_BIT = 3;
  // Reset values
  localparam logic [3:0] CFG_RST = 4'h0;
  localparam logic [BLANK_W-1:0] VCE_BLANK_RST = 10'h064;
  localparam logic [BLANK_W-1:0] OC_BLANK_RST = 10'h032;
  // Operating modes that skip the on-drive check
  localparam logic [2:0] OPM_FIVE = 3'h5;
  localparam logic [2:0] OPM_SIX = 3'h6;
endpackage

// ### tb/gdp_booster_model.sv
// Behavioural booster stage that sits behind the drive lines.
// Assumes the bench raises stuck commands only to provoke a line fault.
`timescale 1ns/10ps
`default_nettype none
module gdp_booster_model (
  // PWM command and fault injection
  input wire logic pwmOn,
  input wire logic stuckOn,
  input wire logic stuckOff,
  // Sensed drive lines
  output logic onDrive,
  output logic offDrive
);
  // Healthy lines follow the command at once; a stuck line shows the wrong level
  assign onDrive = stuckOn ? ~pwmOn : pwmOn;
  assign offDrive = stuckOff ? pwmOn : ~pwmOn;
endmodule
`default_nettype wire

// ### tb/test_gdp_fault_protect.sv
// Self-checking bench for the fault protection block and its booster model.
// Assumes the package constants and an APB slave that answers through pready.
`timescale 1ns/10ps
`default_nettype none
module test_gdp_fault_protect;
  import gdp_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int STAGE_MONITOR = 8;
  logic clk, pready, pslverr, vcePullDown, vceClampOut, outputTristate, emergencyOffReq, emergencySafe, faultNotifyAN;
  logic rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ocCmpLowIn = 1'b0, ocCmpHighIn = 1'b0;
  logic extEnableValidIn = 1'b1, outputDisableIn = 1'b0, pwmOn = 1'b0, turnOnStart = 1'b0, hardOffStart = 1'b0;
  logic plateauActive = 1'b0, stuckOn = 1'b0, stuckOff = 1'b0, boosterOnDriveIn, boosterOffDriveIn, lastSafe, lastErr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] vceCmpIn = 4'h0;
  logic [2:0] opMode = 3'h0;
  logic [9:0] vceBlank, ocBlank;
  int miscompares = 0, numChecks = 0, reqCnt = 0, seed;
  gdp_fault_protect #(.OSM_CYC(STAGE_MONITOR)) gdp_fault_protect_i (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .vceCmpIn, .ocCmpLowIn, .ocCmpHighIn, .extEnableValidIn, .boosterOnDriveIn,
    .boosterOffDriveIn, .outputDisableIn, .pwmOn, .turnOnStart, .plateauActive, .hardOffStart, .opMode,
    .vcePullDown, .vceClampOut, .outputTristate, .emergencyOffReq, .emergencySafe, .faultNotifyAN);
  gdp_booster_model gdp_booster_model_i (.pwmOn(pwmOn), .stuckOn(stuckOn), .stuckOff(stuckOff),
    .onDrive(boosterOnDriveIn), .offDrive(boosterOffDriveIn));
  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Count trip requests; a request held longer than one cycle counts once per cycle
  always @(posedge clk)
  begin
    if (rstn && emergencyOffReq === 1'b1)
    begin
      reqCnt++;
      lastSafe = emergencySafe;
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    numChecks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
    end
  endtask
  // One APB transfer; the request is held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask
  // One PWM edge with its turn-on or hard-off start pulse
  task automatic pwm(input logic on);
    @(posedge clk);
    pwmOn <= on;
    turnOnStart <= on;
    hardOffStart <= ~on;
    plateauActive <= 1'b0;
    @(posedge clk);
    turnOnStart <= 1'b0;
    hardOffStart <= 1'b0;
  endtask
  // Expect exactly one request, its flag and notification, then clear the flag
  task automatic faultChk(input int b, input logic s);
    repeat (8) @(negedge clk);
    chk(reqCnt, 1);
    chk(lastSafe, s);
    chk(faultNotifyAN, 1'b0);
    pwm(1'b0);
    rdChk(ADDR_ERR, 32'h1 << b);
    wr(ADDR_ERR, 32'hf);
    @(negedge clk);
    chk(faultNotifyAN, 1'b1);
    reqCnt = 0;
  endtask
  // ----------------------------------------
  // Sequence and watchdog
  // ----------------------------------------
  initial
  begin
    seed = $urandom(32'h03d63880);
    vceBlank = 10'(4 + $urandom % 8);
    ocBlank = 10'(10 + $urandom % 30);
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rdChk(ADDR_CFG, 32'h0);
    rdChk(ADDR_BLANK, {6'h0, OC_BLANK_RST, 6'h0, VCE_BLANK_RST});
    rdChk(ADDR_STAT, 32'h8);
    rdChk(8'h14, 32'h0);
    chk(lastErr, 1'b1);
    wr(ADDR_BLANK, {6'h0, ocBlank, 6'h0, vceBlank});
    // Only the selected comparator counts, and only after blanking
    for (int s = 0; s < NUM_VCE_THR; s++)
    begin
      wr(ADDR_CFG, s);
      @(posedge clk);
      vceCmpIn <= ~(4'h1 << s);
      pwm(1'b1);
      @(negedge clk);
      chk(vcePullDown, 1'b1);
      repeat (vceBlank) @(negedge clk);
      chk(vcePullDown, 1'b0);
      repeat (4) @(negedge clk);
      chk(reqCnt, 0);
      @(posedge clk);
      vceCmpIn <= 4'h1 << s;
      faultChk(ERR_VCE_BIT, 1'b1);
    end
    // Off state: no supervision, clamp active; open input trips at turn-on
    wr(ADDR_CFG, 32'h4);
    pwm(1'b1);
    pwm(1'b0);
    @(posedge clk);
    vceCmpIn <= 4'hf;
    ocCmpLowIn <= 1'b1;
    repeat (8) @(negedge clk);
    chk(reqCnt, 0);
    chk(vceClampOut, 1'b1);
    chk(vcePullDown, 1'b1);
    wr(ADDR_CFG, 32'h0);
    @(posedge clk);
    ocCmpLowIn <= 1'b0;
    pwm(1'b1);
    repeat (vceBlank) @(negedge clk);
    faultChk(ERR_VCE_BIT, 1'b1);
    // Plateau, then one blanking time after hard off
    @(posedge clk);
    vceCmpIn <= 4'h0;
    pwm(1'b1);
    @(posedge clk);
    plateauActive <= 1'b1;
    repeat (vceBlank + 2) @(negedge clk);
    chk(vcePullDown, 1'b1);
    pwm(1'b0);
    for (int i = 0; i <= vceBlank; i++)
    begin
      @(negedge clk);
      chk(vcePullDown, 1'(i < vceBlank));
    end
    // Overcurrent: ignored and status hidden while blanking, then trips
    @(posedge clk);
    ocCmpLowIn <= 1'b1;
    ocCmpHighIn <= 1'b1;
    pwm(1'b1);
    rdChk(ADDR_STAT, 32'h0, 32'h3);
    repeat (ocBlank - 5) @(negedge clk);
    chk(reqCnt, 0);
    faultChk(ERR_OC_BIT, 1'b1);
    @(posedge clk);
    ocCmpLowIn <= 1'b0;
    ocCmpHighIn <= 1'b0;
    rdChk(ADDR_STAT, 32'hc, 32'hc);
    wr(ADDR_CMD, 32'h1);
    rdChk(ADDR_STAT, 32'h0, 32'h4);
    // External enable going invalid
    @(posedge clk);
    extEnableValidIn <= 1'b0;
    faultChk(ERR_EN_BIT, 1'b0);
    rdChk(ADDR_STAT, 32'h0, 32'h8);
    @(posedge clk);
    extEnableValidIn <= 1'b1;
    // Stuck line: quiet while inhibited, then tristate and trip
    pwm(1'b1);
    @(posedge clk);
    stuckOn <= 1'b1;
    repeat (STAGE_MONITOR - 3) @(negedge clk);
    chk(reqCnt, 0);
    faultChk(ERR_STAGE_BIT, 1'b0);
    chk(outputTristate, 1'b1);
    rdChk(ADDR_STAT, 32'h38);
    @(posedge clk);
    stuckOn <= 1'b0;
    outputDisableIn <= 1'b1;
    repeat (4) @(posedge clk);
    outputDisableIn <= 1'b0;
    repeat (4) @(posedge clk);
    rdChk(ADDR_STAT, 32'h18);
    wr(ADDR_CMD, 32'h2);
    @(negedge clk);
    chk(outputTristate, 1'b0);
    // Cases where the monitor must stay quiet
    pwm(1'b1);
    for (int k = 0; k < 4; k++)
    begin
      wr(ADDR_CFG, k == 0 ? 32'h8 : 32'h0);
      @(posedge clk);
      opMode <= k == 1 ? OPM_FIVE : k == 2 ? OPM_SIX : 3'h0;
      outputDisableIn <= k == 3;
      stuckOn <= k != 0;
      stuckOff <= k == 0;
      repeat (STAGE_MONITOR + 4) @(negedge clk);
      chk(reqCnt, 0);
      chk(outputTristate, k == 3);
      @(posedge clk);
      stuckOn <= 1'b0;
      stuckOff <= 1'b0;
      outputDisableIn <= 1'b0;
      repeat (4) @(posedge clk);
    end
    final_report();
  end
  // The sequence needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire
